// *** dv/aas_far_end.sv ***
// far side of the serial audio port: slave clock source and receiver
`timescale 1ns/100ps
`default_nettype none
module aas_far_end
    import aas_pkg::*;
(
    // controls
    input  wire logic        mclk_i,
    input  wire logic        gen_i,
    input  wire logic        arm_i,
    input  wire logic        dsp_i,
    input  wire logic        lvl_i,
    input  wire logic [7:0]  st_i,
    input  wire logic [7:0]  nb_i,
    input  wire aas_pins_t   pins_i,
    // resolved wires and capture
    output var  logic        bclk_o,
    output var  logic        frame_o,
    output var  logic [63:0] rxd_o,
    output var  logic [63:0] rxo_o,
    output var  logic        rxt_o
);
    logic       fb = 1'b0;
    logic       ff = 1'b0;
    logic       last_d = 1'b0;
    logic       prev = 1'b0;
    logic       lft = 1'b0;
    logic       armed = 1'b0;
    logic [3:0] div = 4'h0;
    logic [4:0] falls = 5'h0;
    logic [7:0] idx = 8'h0;
    logic [7:0] cnt = 8'h0;
    logic       d_w;
    initial rxt_o = 1'b0;
    // released data shows the inverse of its last level: no pull on it
    assign bclk_o  = pins_i.bit_clock_oe_n ? fb : pins_i.bit_clock;
    assign frame_o = pins_i.frame_align_oe_n ? ff : pins_i.frame_align_clock;
    assign d_w = pins_i.serial_sample_oe_n ? ~last_d : pins_i.serial_sample_out;
    // ****************************************
    // slave clocks, bit clock at mclk/32
    // ****************************************
    always @(posedge mclk_i) begin
        if (!pins_i.serial_sample_oe_n)
            last_d <= pins_i.serial_sample_out;
        if (gen_i) begin
            div <= div + 4'h1;
            if (div == 4'h7) begin
                fb <= ~fb;
                // frame moves on a fall, so it is settled at the rise
                if (fb) begin
                    falls <= falls + 5'h1;
                    if (falls == 5'h1F)
                        ff <= ~ff;
                end
            end
        end
    end
    // ****************************************
    // capture on rising bit clock
    // ****************************************
    always @(posedge arm_i) armed = 1'b1;
    always @(posedge bclk_o) begin
        if (dsp_i ? (frame_o && !prev) : (frame_o != prev)) begin
            idx = 8'h0;
            lft = (frame_o == lvl_i);
        end else begin
            idx = idx + 8'h1;
        end
        prev = frame_o;
        if (armed && cnt == 8'h0 && lft && idx == st_i) begin
            cnt   = nb_i + 8'h1;
            rxd_o = '0;
            rxo_o = '0;
        end
        if (cnt != 8'h0) begin
            // left word first; a mono receiver keeps that one
            rxd_o = {rxd_o[62:0], d_w};
            rxo_o = {rxo_o[62:0], pins_i.serial_sample_oe_n};
            cnt   = cnt - 8'h1;
            if (cnt == 8'h0) begin
                armed = 1'b0;
                rxt_o = ~rxt_o;
            end
        end
    end
endmodule
`default_nettype wire

// *** dv/aas_serial_port_tb.sv ***
// self-checking testbench of the serial audio port
`timescale 1ns/100ps
`default_nettype none
module aas_serial_port_tb
    import aas_pkg::*;
;
    localparam logic [15:0] SCN [8] = '{16'h0010, 16'h0068, 16'h0040,
        16'h0098, 16'h0038, 16'h3010, 16'h3098, 16'h2000};
    logic         mclk_i = 1'b0;
    logic         arst_n_i = 1'b0;
    aas_apb_req_t req = '0;
    aas_apb_rsp_t rsp;
    aas_pins_t    pins;
    logic [23:0]  adc_l = '0;
    logic [23:0]  adc_r = '0;
    logic         gen = 1'b0;
    logic         arm = 1'b0;
    logic         dsp = 1'b0;
    logic         lvl = 1'b0;
    logic [7:0]   st = '0;
    logic [7:0]   nb = '0;
    logic         bclk;
    logic         frame;
    logic [63:0]  rxd;
    logic [63:0]  rxo;
    logic         rxt;
    logic [31:0]  seed = 32'h93ED;
    logic [33:0]  apb_q[$];
    logic [127:0] rx_q[$];
    int           err_count = 0;
    int           n_compared = 0;
    int           n_rx = 0;
    int           cyc = 0;
    always #4 mclk_i = ~mclk_i;
    aas_serial_port i_dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
        .apb_req_i(req), .apb_rsp_o(rsp), .adc_left_i(adc_l),
        .adc_right_i(adc_r), .bit_clock_i(bclk),
        .frame_align_clock_i(frame), .pins_o(pins));
    aas_far_end i_far (.mclk_i(mclk_i), .gen_i(gen), .arm_i(arm),
        .dsp_i(dsp), .lvl_i(lvl), .st_i(st), .nb_i(nb), .pins_i(pins),
        .bclk_o(bclk), .frame_o(frame), .rxd_o(rxd), .rxo_o(rxo),
        .rxt_o(rxt));
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d of %0d compares", err_count, n_compared);
        if (err_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // reads note expected data in d, writes send d
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic e);
        apb_q.push_back({~w, d, e});
        @(posedge mclk_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge mclk_i);
        req.penable <= 1'b1;
        // only the cycle ceiling ends a wait that never answers
        do begin
            @(posedge mclk_i);
        end while (rsp.pready !== 1'b1);
        req <= '0;
    endtask
    task automatic run_fmt(input logic [15:0] f, input int half);
        int w;
        int s;
        int k;
        int m;
        logic [1:0] fm;
        logic [31:0] r;
        logic [63:0] ed;
        logic [63:0] eo;
        logic b;
        logic rel;
        fm = f[F_FMT_LO +: 2];
        w = (f[F_WL_LO +: 2] == 2'h3) ? 32 : 16 + 4 * f[F_WL_LO +: 2];
        s = (fm == FMT_LJ) ? 0 : (fm == FMT_I2S) ? 1 : (fm == FMT_DSP) ?
            (f[F_POL_VAR] ? 0 : 1) : half - w * (f[F_SLOT_EN] ? 2 : 1);
        if (f[F_SLOT_SEL])
            s += (fm == FMT_DSP) ? 2 * w : w;
        m = (fm == FMT_DSP) ? 2 * w : w;
        apb(1'b1, OFF_FORMAT, {16'h0, f}, 1'b0);
        r = xs();
        adc_l <= r[23:0];
        r = xs();
        adc_r <= r[23:0];
        dsp <= (fm == FMT_DSP);
        lvl <= (fm != FMT_I2S);
        st <= 8'(s);
        nb <= 8'(m);
        repeat (600) @(posedge mclk_i);
        ed = '0;
        eo = '0;
        for (k = 0; k <= m; k++) begin
            rel = (k == m) ? f[F_SLOT_EN] : (k % w >= 24);
            b = 1'b0;
            if (k < m && !rel)
                b = (k < w) ? adc_l[23 - k % w] : adc_r[23 - k % w];
            ed = {ed[62:0], b};
            eo = {eo[62:0], rel};
        end
        rx_q.push_back({ed, eo});
        arm <= 1'b1;
        @(posedge mclk_i);
        arm <= 1'b0;
        k = n_rx;
        for (int j = 0; j < 3000 && n_rx == k; j++)
            @(posedge mclk_i);
        chk(64'(n_rx - k), 64'h1);
    endtask
    // ****************************************
    // result watchers and sequence
    // ****************************************
    always @(posedge mclk_i) begin
        logic [33:0] n;
        cyc++;
        if (cyc == 60000) begin
            err_count++;
            tally_and_finish();
        end
        if (rsp.pready === 1'b1 && apb_q.size() > 0) begin
            n = apb_q.pop_front();
            if (n[33])
                chk(64'(rsp.prdata), 64'(n[32:1]));
            chk(64'(rsp.pslverr), 64'(n[0]));
        end
    end
    always @(rxt) begin
        logic [127:0] e;
        if (rx_q.size() > 0) begin
            e = rx_q.pop_front();
            chk(rxo, e[63:0]);
            chk(rxd & ~e[63:0], e[127:64]);
            n_rx++;
        end
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, OFF_FORMAT, 32'h0050, 1'b0);
        apb(1'b0, OFF_CLOCK, 32'h0040, 1'b0);
        apb(1'b0, OFF_DIVIDER, 32'h0003, 1'b0);
        apb(1'b1, OFF_FORMAT, 32'hFFFFFFFF, 1'b0);
        apb(1'b0, OFF_FORMAT, 32'h30F8, 1'b0);
        apb(1'b1, 8'h14, 32'h1, 1'b1);
        apb(1'b0, 8'h02, 32'h0, 1'b1);
        apb(1'b1, OFF_DIVIDER, 32'h0, 1'b0);
        apb(1'b1, OFF_CLOCK, 32'h8080, 1'b0);
        repeat (4) @(posedge mclk_i);
        chk({62'h0, pins.bit_clock_oe_n, pins.frame_align_oe_n}, 64'h0);
        for (int i = 0; i < 8; i++)
            run_fmt(SCN[i], 64);
        apb(1'b1, OFF_CLOCK, 32'h0080, 1'b0);
        gen <= 1'b1;
        repeat (4) @(posedge mclk_i);
        chk({62'h0, pins.bit_clock_oe_n, pins.frame_align_oe_n}, 64'h3);
        run_fmt(16'h0010, 32);
        apb(1'b1, OFF_CLOCK, 32'h0880, 1'b0);
        repeat (4) @(posedge mclk_i);
        chk({63'h0, pins.frame_align_oe_n}, 64'h0);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** logic/aas_pkg.sv ***
// constants, register layout and carrier types of the serial audio port
`default_nettype none
package aas_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int DATA_W   = 32;
    localparam int ADDR_W   = 8;
    localparam int SAMPLE_W = 24;
    localparam int POS_W    = 11;
    localparam int DIV_W    = 8;

    // ****************************************
    // register offsets (byte addresses)
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_FORMAT  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_CLOCK   = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_DIVIDER = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 8'h10;

    // ****************************************
    // field positions
    // ****************************************
    localparam int F_SLOT_EN  = 13;
    localparam int F_SLOT_SEL = 12;
    localparam int F_POL_VAR  = 7;
    localparam int F_WL_LO    = 5;
    localparam int F_FMT_LO   = 3;
    localparam int C_MASTER   = 15;
    localparam int C_FORCE    = 11;

    // ****************************************
    // reset values and writable masks
    // ****************************************
    localparam logic [15:0]      RST_FORMAT  = 16'h0050;
    localparam logic [15:0]      RST_CLOCK   = 16'h0040;
    localparam logic [DIV_W-1:0] RST_DIVIDER = 8'h03;
    localparam logic [15:0]      MASK_FORMAT = 16'h30F8;
    localparam logic [15:0]      MASK_CLOCK  = 16'h8FFF;

    // ****************************************
    // encodings
    // ****************************************
    localparam logic [1:0] FMT_RJ  = 2'h0;
    localparam logic [1:0] FMT_LJ  = 2'h1;
    localparam logic [1:0] FMT_I2S = 2'h2;
    localparam logic [1:0] FMT_DSP = 2'h3;
    localparam logic [5:0] WL_BITS_16 = 6'h10;
    localparam logic [5:0] WL_BITS_20 = 6'h14;
    localparam logic [5:0] WL_BITS_24 = 6'h18;
    localparam logic [5:0] WL_BITS_32 = 6'h20;
    localparam logic [POS_W-1:0] POS_ONE = 11'h001;
    localparam logic [POS_W-1:0] POS_MAX = 11'h7FF;

    function automatic logic [5:0] aas_wl_bits(input logic [1:0] code);
        logic [5:0] bits;
        bits = WL_BITS_32;
        unique case (code)
            2'h0: bits = WL_BITS_16;
            2'h1: bits = WL_BITS_20;
            2'h2: bits = WL_BITS_24;
            2'h3: bits = WL_BITS_32;
        endcase
        return bits;
    endfunction

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } aas_apb_req_t;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic              pready;
        logic              pslverr;
    } aas_apb_rsp_t;

    typedef struct packed {
        logic serial_sample_out;
        logic serial_sample_oe_n;
        logic bit_clock;
        logic bit_clock_oe_n;
        logic frame_align_clock;
        logic frame_align_oe_n;
    } aas_pins_t;

    typedef struct packed {
        logic [15:0]         format_word;
        logic [15:0]         clock_word;
        logic [DIV_W-1:0]    divider_word;
        aas_apb_rsp_t        rsp;
        aas_pins_t           pins;
        logic [2:0]          bclk_sync;
        logic [1:0]          frame_sync;
        logic [DIV_W-1:0]    div_cnt;
        logic [POS_W-1:0]    gen_pos;
        logic                frame_at_rise;
        logic [POS_W-1:0]    pos;
        logic [POS_W-1:0]    half_len;
        logic                chan_right;
        logic [SAMPLE_W-1:0] smp_left;
        logic [SAMPLE_W-1:0] smp_right;
    } aas_state_t;

    localparam aas_pins_t PINS_RESET = '{serial_sample_oe_n: 1'b1,
                                         bit_clock_oe_n:     1'b1,
                                         frame_align_oe_n:   1'b1,
                                         default:            1'b0};

    localparam aas_state_t ST_RESET = '{format_word:  RST_FORMAT,
                                        clock_word:   RST_CLOCK,
                                        divider_word: RST_DIVIDER,
                                        pins:         PINS_RESET,
                                        default:      '0};

endpackage
`default_nettype wire

// *** logic/aas_serial_port.sv ***
// serial audio output port with apb register slave
//
// Operation
// - sample data leaves on data line, frame align clock and bit clock.
// - master drives bit and frame clocks; slave takes both as inputs unless bit 11 forces the frame clock out.
// - every format shifts each sample word most significant bit first.
// - slot mode exists in all formats, data in one of two slots.
// - clock control bit 15 selects master (1) or slave (0), resets slave.
// - clock control bit 11 forces frame clock out even as slave.
// - slot mode works both roles, all formats, lengths; enable plus select.
// - format bit 13 enables slots, bit 12 picks slot; both reset 0.
// - in slot mode data line is released before and after own word.
// - word length bits 6:5 give 16, 20, 24, 32; reset 24.
// - format bits 4:3 give rj, lj, i2s, dsp; reset i2s.
// - with 32-bit words the last 8 bit positions stay undriven.
// - bit clock comes from a programmable divider set by software.
// - bit clock, frame clock and data edges sit at repeatable positions.
// - right justified: lsb on last rising edge before frame transition.
// - left justified: msb on first rising edge after frame transition.
// - i2s: msb on second rising edge after frame transition.
// - spare bit clock cycles within a half frame are tolerated.
// - dsp: left msb on first (variant b) or second (a) edge.
// - dsp: right word follows left word without any gap.
// - dsp master: frame clock is one short pulse per sample.
// - dsp mono: left word carries the sample, receiver takes it.
`timescale 1ns/100ps
`default_nettype none
module aas_serial_port
    import aas_pkg::*;
(
    // clock and reset
    input  wire  logic                mclk_i,
    input  wire  logic                arst_n_i,
    // register bus
    input  wire  aas_apb_req_t        apb_req_i,
    output var   aas_apb_rsp_t        apb_rsp_o,
    // converter samples
    input  wire  logic [SAMPLE_W-1:0] adc_left_i,
    input  wire  logic [SAMPLE_W-1:0] adc_right_i,
    // link pins
    input  wire  logic                bit_clock_i,
    input  wire  logic                frame_align_clock_i,
    output var   aas_pins_t           pins_o
);

    // ****************************************
    // state and decoded controls
    // ****************************************
    aas_state_t          st_reg;
    aas_state_t          st_next;
    logic                master;
    logic                force_out;
    logic                frame_self;
    logic                slot_en;
    logic                slot_sel;
    logic                pol_var;
    logic [1:0]          fmt;
    logic                dsp;
    logic [POS_W-1:0]    wl11;
    logic [POS_W-1:0]    rate;
    logic                left_lvl;
    logic                tick;
    logic                rise_ev;
    logic                fall_ev;
    logic [POS_W-1:0]    gen_pos_n;
    logic                frame_gen;
    logic                frame_f;
    logic                trans;
    logic                frame_start;
    logic [POS_W-1:0]    p;
    logic [POS_W-1:0]    hl;
    logic                ch_r;
    logic                latch;
    logic [SAMPLE_W-1:0] smp_l_v;
    logic [SAMPLE_W-1:0] smp_r_v;
    logic [POS_W-1:0]    span;
    logic [POS_W-1:0]    base;
    logic [POS_W-1:0]    soff;
    logic [POS_W-1:0]    rel;
    logic                hit;
    logic                use_right;
    logic [POS_W-1:0]    d;
    logic                in_sample;
    logic [4:0]          bit_idx;
    logic                access;
    logic                mapped;
    logic [DATA_W-1:0]   rdata;

    assign master     = st_reg.clock_word[C_MASTER];
    assign force_out  = st_reg.clock_word[C_FORCE];
    assign frame_self = master | force_out;
    assign slot_en    = st_reg.format_word[F_SLOT_EN];
    assign slot_sel   = st_reg.format_word[F_SLOT_SEL];
    assign pol_var    = st_reg.format_word[F_POL_VAR];
    assign fmt        = st_reg.format_word[F_FMT_LO+:2];
    assign dsp        = (fmt == FMT_DSP);
    assign wl11       = {5'h00, aas_wl_bits(st_reg.format_word[F_WL_LO+:2])};
    assign rate       = st_reg.clock_word[POS_W-1:0];
    // with format bit 7 clear, i2s puts the left word on the low frame level, rj and lj on high
    assign left_lvl   = (fmt != FMT_I2S) ^ pol_var;
    assign access     = apb_req_i.psel & apb_req_i.penable;

    always_comb begin
        st_next     = st_reg;
        tick        = 1'b0;
        rise_ev     = 1'b0;
        fall_ev     = 1'b0;
        gen_pos_n   = '0;
        frame_gen   = 1'b0;
        frame_f     = 1'b0;
        trans       = 1'b0;
        frame_start = 1'b0;
        p           = '0;
        hl          = '0;
        ch_r        = 1'b0;
        latch       = 1'b0;
        smp_l_v     = '0;
        smp_r_v     = '0;
        span        = '0;
        base        = '0;
        soff        = '0;
        rel         = '0;
        hit         = 1'b0;
        use_right   = 1'b0;
        d           = '0;
        in_sample   = 1'b0;
        bit_idx     = '0;
        mapped      = 1'b0;
        rdata       = '0;

        // ****************************************
        // pin synchronisers
        // ****************************************
        st_next.bclk_sync  = {st_reg.bclk_sync[1:0], bit_clock_i};
        st_next.frame_sync = {st_reg.frame_sync[0], frame_align_clock_i};

        // ****************************************
        // bit clock source
        // ****************************************
        // half period is divider_word + 1 master clocks
        if (master) begin
            tick = (st_reg.div_cnt == st_reg.divider_word);
            st_next.div_cnt = tick ? '0 : st_reg.div_cnt + 1'b1;
            if (tick) begin
                st_next.pins.bit_clock = ~st_reg.pins.bit_clock;
            end
            rise_ev = tick & ~st_reg.pins.bit_clock;
            fall_ev = tick & st_reg.pins.bit_clock;
        end else begin
            st_next.div_cnt        = '0;
            st_next.pins.bit_clock = 1'b0;
            rise_ev = st_reg.bclk_sync[1] & ~st_reg.bclk_sync[2];
            fall_ev = ~st_reg.bclk_sync[1] & st_reg.bclk_sync[2];
        end
        st_next.pins.bit_clock_oe_n   = ~master;
        st_next.pins.frame_align_oe_n = ~frame_self;

        // ****************************************
        // frame clock generator
        // ****************************************
        // runs from whichever bit clock is active, so forced output
        // in slave role stays locked to the far bit clock
        gen_pos_n = (st_reg.gen_pos >= rate - POS_ONE) ? '0
                  : st_reg.gen_pos + POS_ONE;
        if (dsp) begin
            frame_gen = (gen_pos_n == '0);
        end else begin
            frame_gen = (gen_pos_n < (rate >> 1)) ? left_lvl : ~left_lvl;
        end
        if (!frame_self) begin
            st_next.gen_pos                = '0;
            st_next.pins.frame_align_clock = 1'b0;
        end else if (fall_ev) begin
            st_next.gen_pos                = gen_pos_n;
            st_next.pins.frame_align_clock = frame_gen;
        end

        // ****************************************
        // frame tracking
        // ****************************************
        if (rise_ev) begin
            st_next.frame_at_rise = frame_self
                                  ? st_reg.pins.frame_align_clock
                                  : st_reg.frame_sync[1];
        end
        frame_f = frame_self ? frame_gen : st_reg.frame_sync[1];
        // a change seen at a fall means the next rise is the first one
        trans       = frame_f ^ st_reg.frame_at_rise;
        frame_start = dsp ? (trans & frame_f) : trans;
        p  = frame_start ? '0
           : (st_reg.pos == POS_MAX) ? st_reg.pos
           : st_reg.pos + POS_ONE;
        hl = frame_start ? st_reg.pos + POS_ONE : st_reg.half_len;
        ch_r  = frame_start ? (~dsp & (frame_f ^ left_lvl))
              : st_reg.chan_right;
        latch = frame_start & (dsp | (frame_f == left_lvl));
        smp_l_v = latch ? adc_left_i : st_reg.smp_left;
        smp_r_v = latch ? adc_right_i : st_reg.smp_right;

        // ****************************************
        // word placement
        // ****************************************
        span = dsp ? (wl11 << 1) : wl11;
        unique case (fmt)
            FMT_RJ:  base = hl - (slot_en ? (wl11 << 1) : wl11);
            FMT_LJ:  base = '0;
            FMT_I2S: base = POS_ONE;
            FMT_DSP: base = pol_var ? '0 : POS_ONE;
        endcase
        soff = (slot_en & slot_sel) ? span : '0;
        rel  = p - base - soff;
        hit  = (rel < span);
        // left word first in dsp; mono receivers take it alone
        use_right = dsp ? (rel >= wl11) : ch_r;
        d = (dsp && rel >= wl11) ? rel - wl11 : rel;
        in_sample = (d < POS_W'(SAMPLE_W));
        bit_idx   = 5'(SAMPLE_W - 1) - d[4:0];

        // ****************************************
        // data line, updated on falling edges
        // ****************************************
        if (fall_ev) begin
            st_next.pos        = p;
            st_next.half_len   = hl;
            st_next.chan_right = ch_r;
            st_next.smp_left   = smp_l_v;
            st_next.smp_right  = smp_r_v;
            if (hit && in_sample) begin
                st_next.pins.serial_sample_out  = use_right
                                                ? smp_r_v[bit_idx]
                                                : smp_l_v[bit_idx];
                st_next.pins.serial_sample_oe_n = 1'b0;
            end else if (hit || slot_en) begin
                st_next.pins.serial_sample_out  = 1'b0;
                st_next.pins.serial_sample_oe_n = 1'b1;
            end else begin
                st_next.pins.serial_sample_out  = 1'b0;
                st_next.pins.serial_sample_oe_n = 1'b0;
            end
        end

        // ****************************************
        // apb slave
        // ****************************************
        // one wait state; writes land on the edge that samples pready
        unique case (apb_req_i.paddr)
            OFF_FORMAT: begin
                mapped = 1'b1;
                rdata  = {16'h0000, st_reg.format_word & MASK_FORMAT};
            end
            OFF_CLOCK: begin
                mapped = 1'b1;
                rdata  = {16'h0000, st_reg.clock_word & MASK_CLOCK};
            end
            OFF_DIVIDER: begin
                mapped = 1'b1;
                rdata  = {24'h000000, st_reg.divider_word};
            end
            OFF_STATUS: begin
                mapped = 1'b1;
                rdata  = {5'h00, st_reg.half_len, 5'h00, st_reg.pos};
            end
            default: begin
                mapped = 1'b0;
                rdata  = '0;
            end
        endcase
        st_next.rsp.pready  = access & ~st_reg.rsp.pready;
        st_next.rsp.pslverr = access & ~st_reg.rsp.pready & ~mapped;
        st_next.rsp.prdata  = (access & ~st_reg.rsp.pready
                               & ~apb_req_i.pwrite) ? rdata : '0;
        if (access && st_reg.rsp.pready && apb_req_i.pwrite) begin
            unique case (apb_req_i.paddr)
                OFF_FORMAT:  st_next.format_word =
                    apb_req_i.pwdata[15:0] & MASK_FORMAT;
                OFF_CLOCK:   st_next.clock_word =
                    apb_req_i.pwdata[15:0] & MASK_CLOCK;
                OFF_DIVIDER: st_next.divider_word =
                    apb_req_i.pwdata[DIV_W-1:0];
                default:     st_next.divider_word = st_reg.divider_word;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign apb_rsp_o = st_reg.rsp;
    assign pins_o    = st_reg.pins;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!arst_n_i);

    a_master_drives_clock: assert property (
        master |=> !pins_o.bit_clock_oe_n)
        else $error("bit clock not driven in master role");

    a_slave_releases_clocks: assert property (
        !master && !force_out |=> pins_o.bit_clock_oe_n
                                  && pins_o.frame_align_oe_n)
        else $error("clock pins driven in slave role");

    a_force_frame_out: assert property (
        force_out |=> !pins_o.frame_align_oe_n)
        else $error("forced frame clock not driven");

    a_msb_leads_word: assert property (
        fall_ev && hit && d == '0 && !use_right
        |=> !pins_o.serial_sample_oe_n
            && pins_o.serial_sample_out == $past(smp_l_v[SAMPLE_W-1]))
        else $error("left word does not start with its msb");

    a_lj_first_edge: assert property (
        fall_ev && frame_start && fmt == FMT_LJ && !slot_en && !ch_r
        |=> pins_o.serial_sample_out == $past(smp_l_v[SAMPLE_W-1]))
        else $error("left justified msb not after transition");

    a_slot_release: assert property (
        fall_ev && slot_en && !hit |=> pins_o.serial_sample_oe_n)
        else $error("data line driven outside own slot");

    a_tail_undriven: assert property (
        fall_ev && hit && !in_sample |=> pins_o.serial_sample_oe_n)
        else $error("padding bits of a long word driven");

    a_divider_period: assert property (
        master && $past(master) && $changed(pins_o.bit_clock)
        |-> $past(st_reg.div_cnt) == $past(st_reg.divider_word))
        else $error("bit clock edge off the divider count");

    a_dsp_short_pulse: assert property (
        master && dsp && rate > POS_ONE && $rose(pins_o.frame_align_clock)
        |-> ##[1:600] $fell(pins_o.frame_align_clock))
        else $error("dsp frame pulse too long");

endmodule
`default_nettype wire
